// ---- logic/utf_pkg.sv ----
// Purpose: Shared constants and types for the serial transmit and format block.
// Assumes: AHB-Lite word registers; 50 MHz system clock.
// Notes: Offsets are byte addresses decoded on haddr[7:0].
package utf_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ADDR_CTRL2 = 8'h08;
    localparam logic [7:0] ADDR_BAUD = 8'h0c;
    localparam logic [7:0] ADDR_DATA = 8'h10;
    // Control register 1 fields.
    localparam int C1_PORT_ON = 0;
    localparam int C1_WL = 1;
    localparam int C1_PAR_ON = 2;
    localparam int C1_PTYPE = 3;
    localparam int C1_RX_STOP = 5;
    localparam int C1_NINTH = 6;
    localparam int C1_ADDR_ON = 7;
    // Control register 2 fields.
    localparam int C2_TX_ON = 0;
    localparam int C2_RX_ON = 1;
    localparam int C2_BRK = 2;
    localparam int C2_TXIE = 3;
    // Baud register fields.
    localparam int BD_FRAC = 16;
    // Reset values.
    localparam logic [15:0] RST_DIV = 16'h0010;
    localparam logic [2:0] RST_FRAC = 3'h0;
    // Parity type encoding.
    localparam logic [1:0] PAR_EVEN = 2'h0;
    localparam logic [1:0] PAR_ODD = 2'h1;
    localparam logic [1:0] PAR_MARK = 2'h2;
    localparam logic [1:0] PAR_SPACE = 2'h3;
    // Bit counts within a frame.
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;
    localparam logic [3:0] STOP_LAST = 4'h1;
    localparam int BRK_ZEROS_DEF = 13;

    typedef struct packed {
        logic [15:0] div;
        logic [2:0] frac;
    } utf_baud_cfg_t;

    typedef struct packed {
        logic port_on;
        logic word_length_select;
        logic parity_on;
        logic [1:0] parity_type_field;
        logic rx_stop_count_select;
        logic tx_ninth_bit;
        logic addr_on;
        logic tx_on;
        logic rx_on;
        logic tx_break_request;
        logic tx_irq_on;
    } utf_ctl_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_START = 3'b001,
        TX_DATA = 3'b010,
        TX_PAR = 3'b011,
        TX_STOP = 3'b100,
        TX_BRK = 3'b101
    } utf_tx_st_t;
endpackage

// ---- logic/utf_sync.sv ----
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Input is asynchronous to clock.
// Notes: The output moves only once stages two and three agree.
`timescale 1ns/10ps
module utf_sync #(
    parameter logic INIT = 1'b1
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } utf_sync_t;

    utf_sync_t s_ff;
    utf_sync_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.s1 = din;
        nxt_s.s2 = s_ff.s1;
        nxt_s.s3 = s_ff.s2;
        if (s_ff.s2 == s_ff.s3) begin
            nxt_s.q = s_ff.s3;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_ff <= {4{INIT}};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign dout = s_ff.q;
endmodule

// ---- logic/utf_baud.sv ----
// Purpose: Bit-time generator with integer divider and fractional stretch.
// Assumes: Divider of at least 2 cycles.
// Notes: While run is low the first bit time is preloaded, so the first
// tick falls exactly one bit time after run rises.
`timescale 1ns/10ps
module utf_baud
    import utf_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input utf_pkg::utf_baud_cfg_t cfg,
    input wire logic run,
    output logic tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic [3:0] acc;
    } utf_baud_t;

    utf_baud_t s_ff;
    utf_baud_t nxt_s;
    logic [3:0] sum;
    logic extra;

    always_comb begin
        nxt_s = s_ff;
        sum = s_ff.acc + {1'b0, cfg.frac};
        // A bit takes one more cycle whenever the sum carries into bit 3.
        extra = s_ff.acc[3] ^ sum[3];
        tick = run && (s_ff.cnt == 16'h0000);
        if (!run) begin
            nxt_s.cnt = cfg.div - 16'h0001;
            nxt_s.acc = {1'b0, cfg.frac};
        end else if (tick) begin
            nxt_s.cnt = cfg.div - 16'h0001 + {15'h0000, extra};
            nxt_s.acc = sum;
        end else begin
            nxt_s.cnt = s_ff.cnt - 16'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule

// ---- logic/utf_top.sv ----
// Purpose: Serial port format control, enable logic and transmit path.
// Assumes: AHB-Lite slave, zero wait states, word accesses only.
// Notes: Receiver data recovery lives elsewhere; its flags are kept here.
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
module utf_top
    import utf_pkg::*;
#(
    parameter int BRK_ZEROS = utf_pkg::BRK_ZEROS_DEF
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic serial_out_pin,
    output logic serial_out_oe,
    input wire logic serial_in_pin,
    output logic serial_in_on,
    output logic tx_irq
);
    import utf_pkg::*;

    if (BRK_ZEROS < 2 || BRK_ZEROS > 15) begin : g_chk
        $error("BRK_ZEROS must lie in 2..15");
    end

    localparam logic [3:0] BRK_LAST = 4'(BRK_ZEROS - 1);

    typedef struct packed {
        utf_ctl_t ctl;
        utf_baud_cfg_t baud;
        utf_tx_st_t st;
        logic [8:0] shreg;
        logic [3:0] bitn;
        logic par;
        logic brk_mode;
        logic [8:0] dbuf;
        logic buf_full;
        logic txe;
        logic idle;
        logic armed;
        logic [4:0] rx_flags;
        logic [2:0] rx_fill_count;
        logic rx_idle;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic line;
        logic oe;
        logic rx_sel;
        logic irq;
        logic [31:0] rdata;
    } utf_top_t;

    utf_top_t s_ff;
    utf_top_t nxt_s;
    logic tick;
    logic rx_lvl;
    logic take;
    logic data_wr;
    logic dw_ok;
    logic direct;
    logic [3:0] last_bit;
    logic [31:0] rd_word;

    ////////////////////////////////////////////////////////////////////////////
    // Shared bit timing and pin input conditioning.

    utf_baud u_baud (
        .clock(clock),
        .srst(srst),
        .cfg(s_ff.baud),
        .run(s_ff.st != TX_IDLE),
        .tick(tick)
    );

    utf_sync #(
        .INIT(1'b1)
    ) u_rx_sync (
        .clock(clock),
        .srst(srst),
        .din(serial_in_pin),
        .dout(rx_lvl)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read-back word for the address being accessed.

    always_comb begin
        rd_word = 32'h0000_0000;
        case (haddr[7:0])
            ADDR_STATUS: begin
                rd_word[10:0] = {s_ff.rx_fill_count, s_ff.rx_flags, s_ff.rx_idle,
                                 s_ff.idle, s_ff.txe};
            end
            ADDR_CTRL1: begin
                rd_word[7:0] = {s_ff.ctl.addr_on, s_ff.ctl.tx_ninth_bit,
                                s_ff.ctl.rx_stop_count_select, s_ff.ctl.parity_type_field,
                                s_ff.ctl.parity_on, s_ff.ctl.word_length_select,
                                s_ff.ctl.port_on};
            end
            ADDR_CTRL2: begin
                rd_word[3:0] = {s_ff.ctl.tx_irq_on, s_ff.ctl.tx_break_request,
                                s_ff.ctl.rx_on, s_ff.ctl.tx_on};
            end
            ADDR_BAUD: begin
                rd_word[18:0] = {s_ff.baud.frac, s_ff.baud.div};
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        nxt_s = s_ff;
        take = hsel && hready && htrans[1];
        data_wr = s_ff.wr_pend && (s_ff.wr_addr == ADDR_DATA);
        // Data is refused whenever the buffer still holds a character.
        dw_ok = data_wr && s_ff.txe && s_ff.ctl.port_on;
        direct = dw_ok && (s_ff.st == TX_IDLE) && s_ff.ctl.tx_on
                 && !s_ff.ctl.tx_break_request && !s_ff.buf_full;
        // The parity bit occupies the last data slot.
        last_bit = (s_ff.ctl.word_length_select ? LAST_BIT_9 : LAST_BIT_8)
                   - {3'h0, s_ff.ctl.parity_on};

        // Register writes complete in the data phase.
        if (s_ff.wr_pend) begin
            case (s_ff.wr_addr)
                ADDR_CTRL1: begin
                    nxt_s.ctl.port_on = hwdata[C1_PORT_ON];
                    nxt_s.ctl.word_length_select = hwdata[C1_WL];
                    nxt_s.ctl.parity_on = hwdata[C1_PAR_ON];
                    nxt_s.ctl.parity_type_field = hwdata[C1_PTYPE +: 2];
                    nxt_s.ctl.rx_stop_count_select = hwdata[C1_RX_STOP];
                    nxt_s.ctl.tx_ninth_bit = hwdata[C1_NINTH];
                    nxt_s.ctl.addr_on = hwdata[C1_ADDR_ON];
                end
                ADDR_CTRL2: begin
                    nxt_s.ctl.tx_on = hwdata[C2_TX_ON];
                    nxt_s.ctl.rx_on = hwdata[C2_RX_ON];
                    nxt_s.ctl.tx_break_request = hwdata[C2_BRK];
                    nxt_s.ctl.tx_irq_on = hwdata[C2_TXIE];
                end
                ADDR_BAUD: begin
                    nxt_s.baud.div = hwdata[15:0];
                    nxt_s.baud.frac = hwdata[BD_FRAC +: 3];
                end
                default: begin
                    nxt_s.wr_pend = 1'b0;
                end
            endcase
        end

        // Status read then data write clears the idle flag.
        if (data_wr) begin
            nxt_s.armed = 1'b0;
            if (s_ff.armed && dw_ok) begin
                nxt_s.idle = 1'b0;
            end
        end
        if (dw_ok && !direct) begin
            nxt_s.dbuf = {s_ff.ctl.tx_ninth_bit, hwdata[7:0]};
            nxt_s.buf_full = 1'b1;
            nxt_s.txe = 1'b0;
        end

        // Transmit sequencer.
        case (s_ff.st)
            TX_IDLE: begin
                nxt_s.par = (s_ff.ctl.parity_type_field == PAR_ODD);
                if (s_ff.ctl.port_on && s_ff.ctl.tx_on) begin
                    if (s_ff.ctl.tx_break_request) begin
                        nxt_s.brk_mode = 1'b1;
                        nxt_s.st = TX_START;
                    end else if (s_ff.buf_full) begin
                        nxt_s.shreg = s_ff.dbuf;
                        nxt_s.buf_full = 1'b0;
                        nxt_s.txe = 1'b1;
                        nxt_s.st = TX_START;
                    end else if (direct) begin
                        // The ninth bit is sampled as the character is loaded.
                        nxt_s.shreg = {s_ff.ctl.tx_ninth_bit, hwdata[7:0]};
                        nxt_s.st = TX_START;
                    end
                end
            end
            TX_START: begin
                if (tick) begin
                    nxt_s.bitn = 4'h0;
                    nxt_s.st = s_ff.brk_mode ? TX_BRK : TX_DATA;
                end
            end
            TX_DATA: begin
                if (tick) begin
                    nxt_s.par = s_ff.par ^ s_ff.shreg[0];
                    nxt_s.shreg = {1'b0, s_ff.shreg[8:1]};
                    nxt_s.bitn = s_ff.bitn + 4'h1;
                    if (s_ff.bitn == last_bit) begin
                        nxt_s.bitn = 4'h0;
                        nxt_s.st = s_ff.ctl.parity_on ? TX_PAR : TX_STOP;
                    end
                end
            end
            TX_PAR: begin
                if (tick) begin
                    nxt_s.st = TX_STOP;
                end
            end
            TX_BRK: begin
                if (tick) begin
                    nxt_s.bitn = s_ff.bitn + 4'h1;
                    if (s_ff.bitn == BRK_LAST) begin
                        nxt_s.bitn = 4'h0;
                        if (!s_ff.ctl.tx_break_request) begin
                            nxt_s.st = TX_STOP;
                        end
                    end
                end
            end
            TX_STOP: begin
                if (tick) begin
                    nxt_s.bitn = s_ff.bitn + 4'h1;
                    if (s_ff.bitn == STOP_LAST) begin
                        nxt_s.bitn = 4'h0;
                        nxt_s.brk_mode = 1'b0;
                        nxt_s.st = TX_IDLE;
                        nxt_s.idle = 1'b1;
                    end
                end
            end
            default: begin
                nxt_s.st = TX_IDLE;
            end
        endcase

        // Losing either enable drops the frame on the spot.
        if (!nxt_s.ctl.port_on || !nxt_s.ctl.tx_on) begin
            nxt_s.st = TX_IDLE;
            nxt_s.brk_mode = 1'b0;
            nxt_s.bitn = 4'h0;
        end
        // Only status, the buffer, tx_on, rx_on and the break request are touched; format, baud and tx_irq_on survive.
        if (!nxt_s.ctl.port_on) begin
            nxt_s.ctl.tx_on = 1'b0;
            nxt_s.ctl.rx_on = 1'b0;
            nxt_s.ctl.tx_break_request = 1'b0;
            nxt_s.rx_flags = 5'h00;
            nxt_s.rx_fill_count = 3'h0;
            nxt_s.txe = 1'b1;
            nxt_s.idle = 1'b1;
            nxt_s.buf_full = 1'b0;
        end

        // Address phase: capture the access, prepare read data.
        nxt_s.wr_pend = take && hwrite;
        nxt_s.wr_addr = haddr[7:0];
        if (take && !hwrite) begin
            nxt_s.rdata = rd_word;
            if (haddr[7:0] == ADDR_STATUS) begin
                nxt_s.armed = 1'b1;
            end
        end

        // Registered pin and request outputs.
        case (nxt_s.st)
            TX_START: nxt_s.line = 1'b0;
            TX_BRK: nxt_s.line = 1'b0;
            TX_DATA: nxt_s.line = nxt_s.shreg[0];
            TX_PAR: begin
                case (s_ff.ctl.parity_type_field)
                    PAR_MARK: nxt_s.line = 1'b1;
                    PAR_SPACE: nxt_s.line = 1'b0;
                    default: nxt_s.line = nxt_s.par;
                endcase
            end
            default: nxt_s.line = 1'b1;
        endcase
        nxt_s.oe = nxt_s.ctl.port_on && nxt_s.ctl.tx_on;
        nxt_s.rx_sel = nxt_s.ctl.port_on && nxt_s.ctl.rx_on;
        nxt_s.rx_idle = !(nxt_s.rx_sel && !rx_lvl);
        nxt_s.irq = nxt_s.ctl.tx_irq_on && nxt_s.txe;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_ff <= '0;
            s_ff.baud.div <= RST_DIV;
            s_ff.baud.frac <= RST_FRAC;
            s_ff.st <= TX_IDLE;
            s_ff.txe <= 1'b1;
            s_ff.idle <= 1'b1;
            s_ff.rx_idle <= 1'b1;
            s_ff.line <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_ff.rdata;
    assign serial_out_pin = s_ff.line;
    assign serial_out_oe = s_ff.oe;
    assign serial_in_on = s_ff.rx_sel;
    assign tx_irq = s_ff.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    idle_line_a: assert property (@(posedge clock) disable iff (srst)
        (s_ff.st == TX_IDLE || s_ff.st == TX_STOP) |-> serial_out_pin)
        else $error("Line not high outside data and start bits.");
    start_low_a: assert property (@(posedge clock) disable iff (srst)
        (s_ff.st == TX_IDLE) ##1 (s_ff.st == TX_START) |-> !serial_out_pin)
        else $error("Start bit not low.");
    two_stop_a: assert property (@(posedge clock) disable iff (srst)
        (s_ff.st == TX_STOP && tick && s_ff.bitn == 4'h0 && serial_out_oe)
        |=> (s_ff.st == TX_STOP) || !serial_out_oe)
        else $error("Frame ended after one stop bit.");
    refuse_write_a: assert property (@(posedge clock) disable iff (srst)
        (data_wr && !s_ff.txe) |=> $stable(s_ff.dbuf))
        else $error("Data write accepted while buffer full.");
    disable_flags_a: assert property (@(posedge clock) disable iff (srst)
        !s_ff.ctl.port_on |-> s_ff.txe && s_ff.idle && !s_ff.ctl.tx_on
        && s_ff.st == TX_IDLE && s_ff.rx_flags == 5'h00)
        else $error("Disabled block holds stale state.");
    txoff_abort_a: assert property (@(posedge clock) disable iff (srst)
        (s_ff.st != TX_IDLE) |-> serial_out_oe)
        else $error("Frame running with transmit disabled.");
    irq_follow_a: assert property (@(posedge clock) disable iff (srst)
        (s_ff.ctl.tx_irq_on && s_ff.txe) |-> tx_irq)
        else $error("Empty flag not raising request.");
    direct_load_a: assert property (@(posedge clock) disable iff (srst)
        direct |=> (s_ff.st == TX_START) && s_ff.txe ##1 !serial_out_pin)
        else $error("Idle write did not start a frame.");
    stop_reload_a: assert property (@(posedge clock) disable iff (srst)
        (s_ff.st == TX_STOP) |=> (s_ff.st != TX_START))
        else $error("Shifter reloaded before stop bits ended.");
    reset_fmt_a: assert property (@(posedge clock)
        $past(srst) && !srst |-> !s_ff.ctl.word_length_select && !s_ff.ctl.parity_on
        && !s_ff.ctl.rx_stop_count_select)
        else $error("Reset format is not 8N1.");
endmodule

// ---- tb/utf_rx_model.sv ----
// Purpose: Far-side serial receiver that decodes frames from the transmit line.
// Assumes: Bit time of DIV clock cycles with no fractional stretch.
// Notes: The receive line is held at its idle high level.
`timescale 1ns/10ps
module utf_rx_model #(
    parameter int DIV = 16
) (
    input wire logic clock,
    input wire logic line,
    input wire logic oe,
    input wire logic [3:0] nbits,
    output logic rx_line,
    output logic [9:0] word,
    output int got
);
    initial begin
        rx_line = 1'b1;
        word = '0;
        got = 0;
    end
    // Sampling mid-bit keeps the decode tolerant of one-cycle edge skew.
    always begin
        @(negedge line iff oe === 1'b1);
        word = '0;
        repeat (DIV / 2) @(posedge clock);
        for (int i = 0; i <= int'(nbits); i++) begin
            repeat (DIV) @(posedge clock);
            word[i] = line;
        end
        got++;
    end
endmodule

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the serial transmit and format block.
// Assumes: Reset divider of 16 cycles per bit, fraction zero outside the stretch scenario.
// Notes: The last decoded slot of each complete character frame is the first stop bit.
`timescale 1ns/10ps
module tb_top;
    import utf_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, txd, txoe, rxd, rx_on_o, tx_irq;
    logic [3:0] nbits = 4'h8;
    logic [9:0] word;
    int got, fails = 0, cmp_count = 0;
    always #10 clock = ~clock;
    assign hready = hreadyout;
    utf_top utf_top_i (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .serial_out_pin(txd), .serial_out_oe(txoe), .serial_in_pin(rxd),
        .serial_in_on(rx_on_o), .tx_irq(tx_irq));
    utf_rx_model utf_rx_model_i (.clock(clock), .line(txd), .oe(txoe), .nbits(nbits),
        .rx_line(rxd), .word(word), .got(got));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        rd = hrdata;
    endtask
    task automatic send(input logic [7:0] d);
        bus(1'b0, ADDR_STATUS, 32'h0);
        bus(1'b1, ADDR_DATA, {24'h0, d});
    endtask
    task automatic wait_got(input int n);
        for (int i = 0; i < 3000 && got < n; i++) @(posedge clock);
        chk("frame count", n, got);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("status", 32'h7, rd);
        bus(1'b0, ADDR_CTRL1, 32'h0);
        chk("ctrl1", 32'h0, rd);
        bus(1'b0, ADDR_BAUD, 32'h0);
        chk("baud", {13'h0, RST_FRAC, RST_DIV}, rd);
        chk("idle line", 1, txd);
        chk("ready", 1, hreadyout);
    endtask
    task automatic t_plain();
        bus(1'b1, ADDR_CTRL1, 32'h1);
        bus(1'b1, ADDR_CTRL2, 32'h3);
        repeat (2) @(posedge clock);
        chk("pins", 3'h7, {txoe, rx_on_o, txd});
        send(8'ha5);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("direct load", 2'h1, rd[1:0]);
        wait_got(1);
        chk("8N frame", 10'h1a5, word);
        repeat (40) @(posedge clock);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("idle set", 1, rd[1]);
    endtask
    task automatic t_parity();
        logic p;
        for (int t = 0; t < 4; t++) begin
            p = (t == 0) ? 1'b1 : (t == 1) ? 1'b0 : (t == 2) ? 1'b1 : 1'b0;
            bus(1'b1, ADDR_CTRL1, 32'h5 | (t << C1_PTYPE));
            send(8'h8b);
            wait_got(2 + t);
            chk("parity frame", {2'h1, p, 7'h0b}, word);
            repeat (40) @(posedge clock);
        end
    endtask
    task automatic t_ninth();
        nbits = 4'h9;
        bus(1'b1, ADDR_CTRL1, 32'h43);
        send(8'h3c);
        wait_got(6);
        chk("9 bit frame", 10'h33c, word);
        repeat (40) @(posedge clock);
        nbits = 4'h8;
        bus(1'b1, ADDR_CTRL1, 32'h1);
    endtask
    task automatic t_buffer();
        send(8'h12);
        send(8'h34);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("buffer full", 0, rd[0]);
        bus(1'b1, ADDR_DATA, 32'h77);
        wait_got(7);
        chk("first", 10'h112, word);
        wait_got(8);
        chk("second", 10'h134, word);
        repeat (400) @(posedge clock);
        chk("no third", 8, got);
    endtask
    task automatic t_irq();
        bus(1'b1, ADDR_CTRL2, 32'h9);
        repeat (3) @(posedge clock);
        chk("irq on", 1, tx_irq);
        bus(1'b1, ADDR_CTRL2, 32'h1);
        repeat (3) @(posedge clock);
        chk("irq off", 0, tx_irq);
    endtask
    task automatic t_disable();
        send(8'h00);
        send(8'h55);
        repeat (30) @(posedge clock);
        bus(1'b1, ADDR_CTRL1, 32'h0);
        repeat (3) @(posedge clock);
        chk("abort pins", 3'h1, {txoe, rx_on_o, txd});
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk("status off", 32'h7, rd);
        bus(1'b0, ADDR_CTRL2, 32'h0);
        chk("ctrl2 off", 32'h0, rd);
        bus(1'b0, ADDR_BAUD, 32'h0);
        chk("baud kept", 32'h10, rd);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("okay resp", 0, hresp);
    endtask
    task automatic low_time(output int n);
        n = 0;
        for (int i = 0; i < 100 && txd !== 1'b0; i++) @(posedge clock);
        while (txd === 1'b0 && n < 1000) begin
            @(posedge clock);
            n++;
        end
    endtask
    task automatic t_break();
        int n;
        bus(1'b1, ADDR_CTRL2, 32'h5);
        bus(1'b1, ADDR_CTRL2, 32'h1);
        low_time(n);
        // The request drops early, so only the start bit and one group of zeros go out.
        chk("break low", int'(RST_DIV) * (1 + BRK_ZEROS_DEF), n);
        wait_got(9);
        chk("break word", 10'h000, word);
        repeat (40) @(posedge clock);
    endtask
    task automatic t_frac();
        int n;
        bus(1'b1, ADDR_BAUD, {13'h0, 3'h3, RST_DIV});
        send(8'h00);
        low_time(n);
        // A fraction of three carries three times over the start and eight data bits.
        chk("stretched low", 9 * int'(RST_DIV) + 3, n);
        wait_got(10);
        chk("stretched frame", 10'h100, word);
        repeat (40) @(posedge clock);
        bus(1'b1, ADDR_BAUD, {13'h0, RST_FRAC, RST_DIV});
    endtask
    task automatic t_txoff();
        send(8'h0f);
        repeat (40) @(posedge clock);
        bus(1'b1, ADDR_CTRL2, 32'h0);
        repeat (3) @(posedge clock);
        chk("tx off pins", 2'h1, {txoe, txd});
        wait_got(11);
        chk("cut frame", 10'h1ff, word);
        send(8'h5a);
        repeat (60) @(posedge clock);
        chk("no send while off", 11, got);
        bus(1'b1, ADDR_CTRL2, 32'h1);
        wait_got(12);
        chk("late enable", 10'h15a, word);
        repeat (40) @(posedge clock);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_plain();
        t_parity();
        t_ninth();
        t_buffer();
        t_break();
        t_frac();
        t_txoff();
        t_irq();
        t_disable();
        end_of_test();
    end
    initial begin
        repeat (30000) @(posedge clock);
        fails++;
        end_of_test();
    end
endmodule
